// File: core/clft_pkg.sv
// Purpose: shared constants and types of the current-limit fault timer
// Assumes: 100 MHz SYS_CLK, 1 ms timer tick
// Notes:   offsets are byte addresses on APB; one register per word
package clft_pkg;

    // clock and tick timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // durations in ms, converted to ticks below (rounded down)
    localparam int LIM_NOM_MS   = 60;
    localparam int LIM_SEL0_MS  = 60;
    localparam int LIM_SEL1_MS  = 15;
    localparam int LIM_SEL2_MS  = 12;
    localparam int LIM_SEL3_MS  = 10;
    localparam int START_SEL0_MS = 60;
    localparam int START_SEL1_MS = 30;
    localparam int START_SEL2_MS = 120;
    localparam int START_SEL3_MS = 15;
    localparam int OVL_MS       = 60;
    localparam int COOL_TIME_MS = 1000;
    localparam int DEC_RATIO    = 16;
    localparam int DEC_W        = 4;

    typedef logic [9:0] clft_ticks_t;

    function automatic clft_ticks_t ms_to_ticks(input int ms);
        return clft_ticks_t'((ms * 1000000) / TICK_PERIOD_NS);
    endfunction

    localparam clft_ticks_t LIM_NOM_TICKS = ms_to_ticks(LIM_NOM_MS);
    localparam clft_ticks_t OVL_TICKS     = ms_to_ticks(OVL_MS);
    localparam clft_ticks_t COOL_TICKS    = ms_to_ticks(COOL_TIME_MS);

    function automatic clft_ticks_t lim_ticks(input logic [1:0] sel);
        case (sel)
            2'h0:    return ms_to_ticks(LIM_SEL0_MS);
            2'h1:    return ms_to_ticks(LIM_SEL1_MS);
            2'h2:    return ms_to_ticks(LIM_SEL2_MS);
            default: return ms_to_ticks(LIM_SEL3_MS);
        endcase
    endfunction

    function automatic clft_ticks_t start_ticks(input logic [1:0] sel);
        case (sel)
            2'h0:    return ms_to_ticks(START_SEL0_MS);
            2'h1:    return ms_to_ticks(START_SEL1_MS);
            2'h2:    return ms_to_ticks(START_SEL2_MS);
            default: return ms_to_ticks(START_SEL3_MS);
        endcase
    endfunction

    // register map
    localparam logic [7:0] REG_TIMING = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CLEAR  = 8'h08;
    localparam logic [7:0] REG_ENABLE = 8'h0C;
    localparam logic [7:0] REG_STATE  = 8'h10;

    localparam int         LIM_LSB    = 6;
    localparam int         START_LSB  = 4;
    localparam logic [7:0] TIMING_RST = 8'h00;

    typedef enum logic [1:0] {
        MODE_OFF      = 2'b00,
        MODE_MANUAL   = 2'b01,
        MODE_SEMIAUTO = 2'b10,
        MODE_AUTO     = 2'b11
    } clft_mode_e;

    typedef enum logic [1:0] {
        ST_OFF   = 2'b00,
        ST_START = 2'b01,
        ST_RUN   = 2'b10,
        ST_COOL  = 2'b11
    } clft_state_e;

endpackage

// File: core/clft_cnt_if.sv
// Purpose: control and result of one fault counter
// Assumes: single SYS_CLK domain
// Notes:   expire is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
interface clft_cnt_if;
    logic                 tick;
    logic                 clear;
    logic                 run;
    logic                 over;
    clft_pkg::clft_ticks_t limit;
    logic                 expire;

    modport ctl (output tick, output clear, output run, output over,
                 output limit, input expire);
    modport cnt (input tick, input clear, input run, input over,
                 input limit, output expire);
endinterface
`default_nettype wire

// File: core/clft_tick.sv
// Purpose: divider making the one-cycle timer tick enable
// Assumes: DIV of at least 2
// Notes:   free running from reset release
`timescale 1ns/1ns
`default_nettype none
module clft_tick #(
    parameter int DIV = clft_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // tick out
    output logic      tick
);
    localparam int W = $clog2(DIV);

    logic [W-1:0] cnt;
    wire          last = (cnt == W'(DIV - 1));

    if (DIV < 2) begin : g_bad_div
        $error("clft_tick: DIV below 2");
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= last ? '0 : W'(cnt + 1'b1);
            tick <= last;
        end
    end
endmodule // clft_tick
`default_nettype wire

// File: core/clft_fault_cnt.sv
// Purpose: up/down fault time counter with time-out pulse
// Assumes: tick is a one-cycle enable
// Notes:   serves both current-limit and overload timing
`timescale 1ns/1ns
`default_nettype none
module clft_fault_cnt (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  srst,
    // counter control
    clft_cnt_if.cnt    c
);
    clft_pkg::clft_ticks_t          cnt;
    logic [clft_pkg::DEC_W-1:0]     pre;

    wire clft_pkg::clft_ticks_t next_up = clft_pkg::clft_ticks_t'(cnt + 1'b1);
    wire hit     = (next_up >= c.limit);
    wire pre_end = (pre == clft_pkg::DEC_W'(clft_pkg::DEC_RATIO - 1));
    wire step    = c.tick & c.run;

    always_ff @(posedge clk) begin
        if (srst || c.clear) begin
            cnt      <= '0;
            pre      <= '0;
            c.expire <= 1'b0;
        end else begin
            c.expire <= step & c.over & hit;
            if (step && c.over) begin
                cnt <= hit ? '0 : next_up;
            end else if (step) begin
                // down at one sixteenth of the up rate
                pre <= clft_pkg::DEC_W'(pre + 1'b1); // RULE_05
                if (pre_end && cnt != '0) begin // RULE_06
                    cnt <= clft_pkg::clft_ticks_t'(cnt - 1'b1); // RULE_05
                end
            end
        end
    end
endmodule // clft_fault_cnt
`default_nettype wire

// File: core/clft_top.sv
// Purpose: per-channel current-limit, start-up and overload fault timing
// Assumes: channel inputs synchronous to SYS_CLK; commands are pulses
// Notes:   APB4 slave, one wait state on every access
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// RULE_01 - foldback bit clear: fixed nominal 60 ms
// RULE_02 - foldback bit set: time-out from bits 7:6
// RULE_03 - count up after window, while clamping
// RULE_04 - time-out: switch off, 1 s cool-down
// RULE_05 - below limit: count down at 1/16 rate
// RULE_06 - counter never goes below zero
// RULE_07 - off, reset, disconnect, shutdown clear counter
// RULE_08 - limit field rewrite restarts the timer
// RULE_09 - semiauto cool-down end restarts detection
// RULE_10 - reset, off or manual cancel cool-down
// RULE_11 - window field bits 5:4, RW, resets zero
// RULE_12 - inrush clamp at window end: off, cool-down
// RULE_13 - overload timer runs despite cut disable
// RULE_14 - independent timers for every channel
module clft_top #(
    parameter int NCH         = 4,
    parameter int TICK_CYCLES = clft_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic             SYS_CLK,
    input  wire logic             SRST,
    // apb slave
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [7:0]       PADDR,
    input  wire logic [31:0]      PWDATA,
    input  wire logic [3:0]       PSTRB,
    output logic                  PREADY,
    output logic [31:0]           PRDATA,
    output logic                  PSLVERR,
    output logic                  IRQ,
    // channel conditions
    input  wire logic [NCH-1:0]   CHAN_ON,
    input  wire logic [NCH-1:0]   OUTPUT_CURRENT_CLAMP,
    input  wire logic [NCH-1:0]   INRUSH_CLAMP,
    input  wire logic [NCH-1:0]   OVERLOAD_POWER_CUT,
    // commands and events
    input  wire logic [NCH-1:0]   PWR_OFF_CMD,
    input  wire logic [NCH-1:0]   RESET_CMD,
    input  wire logic [NCH-1:0]   DC_DISCONNECT,
    input  wire logic             FAST_PORT_SHUTDOWN_IN,
    // configuration from other registers
    input  wire logic [2*NCH-1:0] MODE,
    input  wire logic [NCH-1:0]   DETECT_EN,
    input  wire logic [NCH-1:0]   DOUBLE_FOLDBACK_EN,
    input  wire logic [NCH-1:0]   OVERLOAD_CUT_DISABLE,
    // channel actions
    output logic [NCH-1:0]        CHAN_OFF_REQ,
    output logic [NCH-1:0]        COOL_ACTIVE,
    output logic [NCH-1:0]        DETECT_RESTART
);
    // status packs four fields of NCH bits into one word
    if (NCH < 1 || NCH > 8) begin : g_bad_nch
        $error("clft_top: NCH must be 1 to 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    logic [7:0]  timing;
    logic [31:0] status;
    logic [31:0] enable;
    logic        pready;

    wire acc       = PSEL & PENABLE;
    wire first     = acc & ~pready;
    wire done      = acc & pready;
    wire hit_tim   = (PADDR == clft_pkg::REG_TIMING);
    wire hit_stat  = (PADDR == clft_pkg::REG_STATUS);
    wire hit_clr   = (PADDR == clft_pkg::REG_CLEAR);
    wire hit_en    = (PADDR == clft_pkg::REG_ENABLE);
    wire hit_state = (PADDR == clft_pkg::REG_STATE);
    wire mapped    = hit_tim | hit_stat | hit_clr | hit_en | hit_state;
    wire wr        = done & PWRITE & mapped;

    wire [31:0] wmask = {{8{PSTRB[3]}}, {8{PSTRB[2]}},
                         {8{PSTRB[1]}}, {8{PSTRB[0]}}};
    wire        wr_tim = wr & hit_tim & PSTRB[0];
    wire [31:0] clr_mask = (wr && hit_clr) ? (PWDATA & wmask) : 32'h0;

    wire [1:0] lim_sel   = timing[clft_pkg::LIM_LSB +: 2];
    wire [1:0] start_sel = timing[clft_pkg::START_LSB +: 2];

    // a rewrite of the same value keeps timers running
    wire lim_changed =
        wr_tim && (PWDATA[clft_pkg::LIM_LSB +: 2] != lim_sel); // RULE_08

    ////////////////////////////////////////////////////////////////////////
    // timer tick

    logic tick;

    clft_tick #(
        .DIV (TICK_CYCLES)
    ) u_tick (
        .clk  (SYS_CLK),
        .srst (SRST),
        .tick (tick)
    );

    wire clft_pkg::clft_ticks_t start_lim =
        clft_pkg::start_ticks(start_sel);
    wire clft_pkg::clft_ticks_t sel_lim = clft_pkg::lim_ticks(lim_sel);

    ////////////////////////////////////////////////////////////////////////
    // per-channel sequencing

    wire [NCH-1:0] ev_lim;
    wire [NCH-1:0] ev_start;
    wire [NCH-1:0] ev_ovl;
    wire [NCH-1:0] ev_cool;
    wire [NCH-1:0] in_run;
    wire [NCH-1:0] next_off;
    wire [NCH-1:0] next_cool;
    wire [NCH-1:0] next_det;

    // one copy each of counters and state; only the tick and the timing selects are shared
    for (genvar i = 0; i < NCH; i++) begin : g_ch // RULE_14
        clft_cnt_if lim_if ();
        clft_cnt_if ovl_if ();

        clft_pkg::clft_state_e state;
        clft_pkg::clft_state_e next_state;
        clft_pkg::clft_ticks_t win;

        wire [1:0] mode    = MODE[2*i +: 2];
        wire       off_evt = PWR_OFF_CMD[i] | RESET_CMD[i] |
                             DC_DISCONNECT[i] | FAST_PORT_SHUTDOWN_IN;
        wire       cancel  = RESET_CMD[i] |
                             (mode == clft_pkg::MODE_OFF) |
                             (mode == clft_pkg::MODE_MANUAL); // RULE_10
        wire       is_run  = (state == clft_pkg::ST_RUN);
        wire       is_cool = (state == clft_pkg::ST_COOL);

        wire clft_pkg::clft_ticks_t win_lim =
            is_cool ? clft_pkg::COOL_TICKS : start_lim;
        wire clft_pkg::clft_ticks_t win_next =
            clft_pkg::clft_ticks_t'(win + 1'b1);
        wire win_done = tick & (win_next >= win_lim);

        wire start_trip = (state == clft_pkg::ST_START) & win_done &
                          INRUSH_CLAMP[i]; // RULE_12
        wire lim_trip = is_run & lim_if.expire;
        wire ovl_trip = is_run & ovl_if.expire; // RULE_13
        // cut disabled: flag only, channel stays on
        wire ovl_off  = ovl_trip & ~OVERLOAD_CUT_DISABLE[i]; // RULE_13
        wire cool_end = is_cool & win_done & ~cancel;

        assign lim_if.tick  = tick;
        // leaving run covers every turn-off event
        assign lim_if.clear = ~is_run | lim_changed; // RULE_07 RULE_08
        assign lim_if.run   = is_run; // RULE_03
        assign lim_if.over  = OUTPUT_CURRENT_CLAMP[i]; // RULE_03
        assign lim_if.limit = DOUBLE_FOLDBACK_EN[i] ? sel_lim // RULE_02
                                                    : clft_pkg::LIM_NOM_TICKS;
                                                    // RULE_01

        assign ovl_if.tick  = tick;
        assign ovl_if.clear = ~is_run;
        assign ovl_if.run   = is_run;
        assign ovl_if.over  = OVERLOAD_POWER_CUT[i];
        assign ovl_if.limit = clft_pkg::OVL_TICKS;

        clft_fault_cnt u_lim (
            .clk  (SYS_CLK),
            .srst (SRST),
            .c    (lim_if.cnt)
        );

        clft_fault_cnt u_ovl (
            .clk  (SYS_CLK),
            .srst (SRST),
            .c    (ovl_if.cnt)
        );

        always_comb begin
            next_state = state;
            case (state)
                clft_pkg::ST_OFF: begin
                    if (CHAN_ON[i] && !off_evt) begin
                        next_state = clft_pkg::ST_START;
                    end
                end
                clft_pkg::ST_START: begin
                    if (off_evt || !CHAN_ON[i]) begin
                        next_state = clft_pkg::ST_OFF;
                    end else if (start_trip) begin
                        next_state = clft_pkg::ST_COOL; // RULE_12
                    end else if (win_done) begin
                        next_state = clft_pkg::ST_RUN;
                    end
                end
                clft_pkg::ST_RUN: begin
                    if (lim_trip || ovl_off) begin
                        next_state = clft_pkg::ST_COOL; // RULE_04
                    end else if (off_evt || !CHAN_ON[i]) begin
                        next_state = clft_pkg::ST_OFF; // RULE_07
                    end
                end
                clft_pkg::ST_COOL: begin
                    // channel on is ignored until the count completes or cancel is set
                    if (cancel || win_done) begin // RULE_04 RULE_10
                        next_state = clft_pkg::ST_OFF;
                    end
                end
                default: next_state = clft_pkg::ST_OFF;
            endcase
        end

        always_ff @(posedge SYS_CLK) begin
            if (SRST) begin
                state <= clft_pkg::ST_OFF;
                win   <= '0;
            end else begin
                state <= next_state;
                if (next_state != state) begin
                    win <= '0;
                end else if (tick) begin
                    win <= win_next;
                end
            end
        end

        assign ev_lim[i]    = lim_trip;
        assign ev_start[i]  = start_trip;
        assign ev_ovl[i]    = ovl_trip;
        assign ev_cool[i]   = cool_end;
        assign in_run[i]    = is_run;
        assign next_off[i]  = start_trip | lim_trip | ovl_off; // RULE_04
        assign next_cool[i] = (next_state == clft_pkg::ST_COOL);
        assign next_det[i]  = cool_end & DETECT_EN[i] &
                              (mode == clft_pkg::MODE_SEMIAUTO); // RULE_09
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and interrupt

    wire [31:0] events      = 32'({ev_cool, ev_ovl, ev_start, ev_lim});
    // a new event beats a clear in the same cycle
    wire [31:0] next_status = (status & ~clr_mask) | events;
    wire [31:0] state_word  = 32'({in_run, COOL_ACTIVE});
    wire [31:0] valid_bits  = 32'({(4*NCH){1'b1}});

    wire [31:0] rd_mux =
        hit_tim   ? {24'h000000, timing} :
        hit_stat  ? status :
        hit_en    ? enable :
        hit_state ? state_word :
                    32'h00000000;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            pready  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else begin
            pready  <= first;
            PSLVERR <= first & ~mapped;
            if (first) begin
                PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            timing <= clft_pkg::TIMING_RST; // RULE_11
            enable <= 32'h00000000;
            status <= 32'h00000000;
            IRQ    <= 1'b0;
        end else begin
            if (wr_tim) begin
                timing <= PWDATA[7:0]; // RULE_11
            end
            if (wr && hit_en) begin
                enable <= ((enable & ~wmask) | (PWDATA & wmask)) & valid_bits;
            end
            status <= next_status;
            IRQ    <= |(next_status & enable);
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            CHAN_OFF_REQ   <= '0;
            COOL_ACTIVE    <= '0;
            DETECT_RESTART <= '0;
        end else begin
            CHAN_OFF_REQ   <= next_off;
            COOL_ACTIVE    <= next_cool;
            DETECT_RESTART <= next_det;
        end
    end

    assign PREADY = pready;

endmodule // clft_top
`default_nettype wire

// File: test/clft_top_chk.sv
// Purpose: port-level assertions for clft_top
// Assumes: one clock domain, SRST synchronous
// Notes:   cool-down timing watched on channel 0 only
`timescale 1ns/1ns
`default_nettype none
module clft_top_chk #(
    parameter int NCH         = 4,
    parameter int TICK_CYCLES = 4
) (
    // clock, reset and bus answer
    input wire logic             SYS_CLK,
    input wire logic             SRST,
    input wire logic             PSEL,
    input wire logic             PENABLE,
    input wire logic             PREADY,
    input wire logic             PSLVERR,
    // channel side
    input wire logic [NCH-1:0]   RESET_CMD,
    input wire logic [2*NCH-1:0] MODE,
    input wire logic [NCH-1:0]   DETECT_EN,
    input wire logic [NCH-1:0]   CHAN_OFF_REQ,
    input wire logic [NCH-1:0]   COOL_ACTIVE,
    input wire logic [NCH-1:0]   DETECT_RESTART
);
    localparam int COOL_MIN = 999 * TICK_CYCLES;
    localparam int COOL_MAX = 1001 * TICK_CYCLES;
    logic [31:0] cool_cnt;
    wire  [31:0] next_cool_cnt = COOL_ACTIVE[0] ? cool_cnt + 32'h1 : 32'h0;

    always_ff @(posedge SYS_CLK) begin
        cool_cnt <= SRST ? 32'h0 : next_cool_cnt;
    end

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    ////////////////////////////////////////////////////////////////////////
    a_cool_off_req: assert property (
        $rose(COOL_ACTIVE[0]) |-> CHAN_OFF_REQ[0])
        else $error("cool-down began without switch-off");
    a_off_one_cycle: assert property (
        CHAN_OFF_REQ[0] |=> !CHAN_OFF_REQ[0])
        else $error("switch-off request longer than a cycle");
    a_cool_hold: assert property (
        COOL_ACTIVE[0] && cool_cnt < COOL_MIN &&
        !RESET_CMD[0] && MODE[1] |=> COOL_ACTIVE[0])
        else $error("cool-down ended early");
    a_cool_bound: assert property (
        COOL_ACTIVE[0] |-> cool_cnt <= COOL_MAX)
        else $error("cool-down too long");
    a_reset_cancel: assert property (
        RESET_CMD[0] |-> ##[1:2] !COOL_ACTIVE[0])
        else $error("reset command kept cool-down");
    a_mode_cancel: assert property (
        (!MODE[1]) [*2] |-> ##[0:1] !COOL_ACTIVE[0])
        else $error("off or manual mode kept cool-down");
    a_restart_after: assert property (
        $fell(COOL_ACTIVE[0]) && !$past(RESET_CMD[0]) &&
        MODE[1:0] == 2'h2 && DETECT_EN[0] |-> ##[0:1] DETECT_RESTART[0])
        else $error("no detection restart after cool-down");
    a_restart_cause: assert property (
        DETECT_RESTART[0] |-> MODE[1:0] == 2'h2 && DETECT_EN[0])
        else $error("detection restart without semiauto and enable");
    a_apb_wait: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
        else $error("bus answer not after one wait state");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error flag outside bus answer");
endmodule // clft_top_chk
bind clft_top clft_top_chk #(.NCH(NCH), .TICK_CYCLES(TICK_CYCLES)) i_chk (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RESET_CMD(RESET_CMD), .MODE(MODE),
    .DETECT_EN(DETECT_EN), .CHAN_OFF_REQ(CHAN_OFF_REQ),
    .COOL_ACTIVE(COOL_ACTIVE), .DETECT_RESTART(DETECT_RESTART));
`default_nettype wire

// File: test/clft_switch_model.sv
// Purpose: behavioural port power switch with current sensing
// Assumes: want_on and hit inputs come from the bench
// Notes:   a switch that is off cannot clamp
`timescale 1ns/1ns
`default_nettype none
module clft_switch_model #(
    parameter int NCH = 2
) (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           srst,
    // stimulus and device actions
    input  wire logic [NCH-1:0] want_on,
    input  wire logic [NCH-1:0] limit_hit,
    input  wire logic [NCH-1:0] inrush_hit,
    input  wire logic [NCH-1:0] off_req,
    input  wire logic [NCH-1:0] cool,
    // switch state
    output logic [NCH-1:0]      chan_on,
    output logic [NCH-1:0]      oclamp,
    output logic [NCH-1:0]      iclamp
);
    // refuses to switch on while the device holds cool-down
    always_ff @(posedge clk) begin
        chan_on <= srst ? '0 : want_on & ~cool & ~off_req;
    end
    assign oclamp = chan_on & limit_hit;
    assign iclamp = chan_on & inrush_hit;
endmodule // clft_switch_model
`default_nettype wire

// File: test/testbench.sv
// Purpose: self-checking bench for clft_top
// Assumes: TICK_CYCLES shortened to 4
// Notes:   expected times are in ticks, tolerance two ticks
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int TC = 4;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr, irq, fast_port_shutdown_in;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0]  want, lhit, ihit, poff, rcmd, dcd, den, fb, ls, ss, ovl, ocd;
    logic [1:0]  on, oclamp, iclamp, off_req, cool, restart;
    logic [3:0]  mode;
    logic        e, cool1_seen;
    int          error_cnt, comparisons, n;

    clft_top #(.NCH(2), .TICK_CYCLES(TC)) i_dut (.SYS_CLK(clk), .SRST(srst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(4'hF), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .IRQ(irq), .CHAN_ON(on), .OUTPUT_CURRENT_CLAMP(oclamp),
        .INRUSH_CLAMP(iclamp), .OVERLOAD_POWER_CUT(ovl), .PWR_OFF_CMD(poff),
        .RESET_CMD(rcmd), .DC_DISCONNECT(dcd), .FAST_PORT_SHUTDOWN_IN(fast_port_shutdown_in),
        .MODE(mode), .DETECT_EN(den), .DOUBLE_FOLDBACK_EN(fb),
        .OVERLOAD_CUT_DISABLE(ocd), .CHAN_OFF_REQ(off_req),
        .COOL_ACTIVE(cool), .DETECT_RESTART(restart));
    clft_switch_model #(.NCH(2)) i_sw (.clk(clk), .srst(srst), .want_on(want),
        .limit_hit(lhit), .inrush_hit(ihit), .off_req(off_req), .cool(cool),
        .chan_on(on), .oclamp(oclamp), .iclamp(iclamp));

    ////////////////////////////////////////////////////////////////////////
    function automatic int lim_t(input logic f, input logic [1:0] s);
        return !f ? 60 : (s == 0 ? 60 : s == 1 ? 15 : s == 2 ? 12 : 10);
    endfunction
    function automatic int start_t(input logic [1:0] s);
        return s == 0 ? 60 : s == 1 ? 30 : s == 2 ? 120 : 15;
    endfunction
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic set_t(input logic [1:0] l, input logic [1:0] s);
        ls = l; ss = s;
        apb(1'b1, clft_pkg::REG_TIMING, {24'h0, l, s, 4'h0});
    endtask
    task automatic go();
        want[0] <= 1'b1;
        wt((start_t(ss) + 2) * TC);
    endtask
    // clamps channel 0 and times the switch-off from here
    task automatic trip(input logic inr, input int x);
        @(posedge clk);
        if (inr) begin ihit[0] <= 1'b1; want[0] <= 1'b1; end else lhit[0] <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (off_req[0] !== 1'b1 && n < 3000);
        chk(n >= (x - 2) * TC && n <= (x + 2) * TC + 6, "switch-off time");
        chk(cool[0] === 1'b1, "cool-down not started");
        want[0] <= 1'b0; lhit[0] <= 1'b0; ihit[0] <= 1'b0;
    endtask
    // by mode: odd limit select picks manual, even picks off
    task automatic cancel(input logic by_mode);
        @(posedge clk);
        if (by_mode) mode[1:0] <= {1'b0, ls[0]}; else rcmd[0] <= 1'b1;
        @(posedge clk);
        rcmd[0] <= 1'b0;
        wt(3);
        chk(cool[0] === 1'b0, "cool-down not cancelled");
        mode[1:0] <= 2'h2;
    endtask
    task automatic results();
        $display("error_cnt=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin clk = 1'b0; forever #5 clk = ~clk; end
    initial begin wt(80000); error_cnt++; $display("MISMATCH t=%0t hang", $time); results(); end
    // channel 1 must never be switched off; outputs are unknown in reset
    always @(posedge clk) begin
        if (!srst && (cool[1] !== 1'b0 || off_req[1] !== 1'b0)) begin
            cool1_seen <= 1'b1;
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, fast_port_shutdown_in, cool1_seen} = '0;
        {want, lhit, ihit, poff, rcmd, dcd, den, fb, ovl, ocd} = '0;
        mode = 4'hA; srst = 1'b1; error_cnt = 0; comparisons = 0;
        void'($urandom(32'h44AC));
        wt(6);
        srst <= 1'b0;
        want[1] <= 1'b1;
        apb(1'b0, clft_pkg::REG_TIMING, 32'h0); chk(r === 32'h0, "timing reset");
        set_t(2'h0, 2'h3); apb(1'b0, clft_pkg::REG_TIMING, 32'h0);
        chk(r[7:0] === 8'h30, "window field");
        apb(1'b0, 8'h20, 32'h0); chk(e === 1'b1, "unmapped read");
        apb(1'b1, clft_pkg::REG_ENABLE, 32'h1);
        set_t(2'h3, 2'h3); go(); trip(1'b0, lim_t(1'b0, 2'h3));
        wt(2); chk(irq === 1'b1, "irq not raised");
        apb(1'b0, clft_pkg::REG_STATUS, 32'h0); chk(r[0] === 1'b1, "status bit");
        apb(1'b1, clft_pkg::REG_CLEAR, 32'h1); wt(2); chk(irq === 1'b0, "irq cleared");
        apb(1'b1, clft_pkg::REG_ENABLE, 32'h0);
        cancel(1'b0);
        fb <= 2'h3;
        for (int k = 0; k < 4; k++) begin
            set_t(2'(k), 2'($urandom_range(3)));
            go(); trip(1'b0, lim_t(1'b1, 2'(k))); cancel(k[0]);
        end
        chk(irq === 1'b0, "masked irq");
        set_t(2'h1, 2'h3); go();
        lhit[0] <= 1'b1; wt(10 * TC); lhit[0] <= 1'b0; wt(320 * TC);
        lhit[0] <= 1'b1; wt(8 * TC); lhit[0] <= 1'b0; wt(64 * TC);
        trip(1'b0, 11); cancel(1'b0);
        for (int k = 0; k < 4; k++) begin
            go(); lhit[0] <= 1'b1; wt(10 * TC);
            case (k)
                0: poff[0] <= 1'b1;
                1: rcmd[0] <= 1'b1;
                2: dcd[0] <= 1'b1;
                default: fast_port_shutdown_in <= 1'b1;
            endcase
            want[0] <= 1'b0; lhit[0] <= 1'b0;
            @(posedge clk);
            {poff, rcmd, dcd, fast_port_shutdown_in} <= '0;
            wt(2); go(); trip(1'b0, 15); cancel(1'b0);
        end
        set_t(2'h0, 2'h3); go(); lhit[0] <= 1'b1; wt(30 * TC);
        set_t(2'h2, 2'h3); trip(1'b0, 12); cancel(1'b1);
        trip(1'b1, start_t(2'h3)); cancel(1'b0);
        ovl[1] <= 1'b1; ocd[1] <= 1'b1;
        den[0] <= 1'b1; set_t(2'h3, 2'h3); go(); trip(1'b0, 10);
        n = 0;
        do begin @(posedge clk); n++; end while (restart[0] !== 1'b1 && n < 1010 * TC);
        chk(restart[0] === 1'b1 && n >= 998 * TC, "detection restart");
        chk(cool1_seen === 1'b0, "other channel disturbed");
        apb(1'b0, clft_pkg::REG_STATUS, 32'h0);
        chk(r[5] === 1'b1, "overload flag on channel 1");
        results();
    end
endmodule // testbench
`default_nettype wire
